/* File: apm_defs.svh */
// Register offsets, field positions, reset values and summary of the pixel mapper
// What this block does
// - Line graphics, nine-dot box: ninth dot copies eighth for codes C0..DF.
// - Line graphics on, nine-dot box: ninth dot is zero for all other codes.
// - Line graphics off, nine-dot box: ninth dot is plane 3 bit 7.
// - Boxes over nine dots take extra dots from plane 3 bits 7, 6, onward.
// - Mode bit 1 high selects mono attributes, low selects colour attributes.
// - Mode bit 0 high treats pixels as graphics, low as text.
// - Border colour register drives all eight colour outputs outside the screen.
// - Plane enable bits 5:4 pick which colour pair shows in status 5:4.
// - Plane enable bits 3:0 gate planes 0..3 into the pixel value in graphics mode only.
// - Panning field shifts video left by up to nine pixels.
// - Nine-dot modes: pan 8 no shift, 0..7 shift one to eight.
// - Six-dot pan 2 and seven-dot pan 1 mean no shift.
// - Colour select 3:2 give high colour bits; 256-colour bytes pass unchanged.
// - Mode bit 7 high: colour select 1:0 replace palette bits 5:4.
// - Bypass bit high: output equals palette input value.
// - Width field 00 gives eight bits per clock, 10 gives sixteen.
// - DAC protect high ignores palette writes; resets to zero.
// - Border protect high ignores writes to border bits 3:0; resets to zero.
// - Registers 16 and 17 take writes only while the key is unlocked.
// - Redefine bit protects palette; mono bits mean reverse, half, invisible, underline.
// - Colour redefinition: bits 7:5 background, 4:2 foreground, 1:0 font.
// - Mono redefinition: bits 2:0 select font; sequencer font register ignored.
// - Blinking toggles palette address bit 3 between lower and upper halves.
`ifndef APM_DEFS_SVH
`define APM_DEFS_SVH
`define APM_IDX_MODE       5'h10
`define APM_IDX_BORDER     5'h11
`define APM_IDX_PLANE      5'h12
`define APM_IDX_SHIFT      5'h13
`define APM_IDX_HICOLOR    5'h14
`define APM_IDX_OUTCFG     5'h16
`define APM_IDX_REDEF      5'h17
`define APM_MASK_MODE      8'hef
`define APM_MASK_PLANE     8'h3f
`define APM_MASK_SHIFT     8'h0f
`define APM_MASK_HICOLOR   8'h0f
`define APM_MASK_OUTCFG    8'hf3
`define APM_MASK_REDEF     8'h80
`define APM_REG_RESET      8'h00
`define APM_MODE_GFX       0
`define APM_MODE_MONO      1
`define APM_MODE_LGFX      2
`define APM_MODE_BLINK     3
`define APM_MODE_SECSEL    7
`define APM_CFG_BPROT      0
`define APM_CFG_DPROT      1
`define APM_CFG_BYPASS     7
`define APM_REDEF_BIT      7
`define APM_WIDE_CODE      2'b10
`define APM_LG_LO          8'hc0
`define APM_LG_HI          8'hdf
`define APM_HALF_LEVEL     8'h08
`define APM_FULL_LEVEL     8'h18
`define APM_FIFO_DEPTH     8
`define APM_PAN_TAPS       10
`endif

/* File: apm_pkg.sv */
// Types shared by the pixel mapper modules
package apm_pkg;
	typedef enum logic [0:0] {
		APM_PORT_INDEX = 1'b0,
		APM_PORT_DATA  = 1'b1
	} apm_port_e;
	typedef enum logic [1:0] {
		APM_SEL_ATTR   = 2'b00,
		APM_SEL_DATA   = 2'b01,
		APM_SEL_STATUS = 2'b10
	} apm_io_sel_e;
	typedef logic [7:0] apm_color_t;
endpackage

/* File: apm_fifo.sv */
// Pixel word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module apm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data  = mem_ff[rd_ff];
	always_ff @(posedge clock) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_ff    <= '0;
			rd_ff    <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* File: apm_palette_mem.sv */
// Sixteen-entry palette memory, one write port and two registered read ports
`timescale 1ns/1ps
module apm_palette_mem (
	input  wire logic       clock,
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_addr,
	input  wire logic [5:0] wr_data,
	input  wire logic       rda_en,
	input  wire logic [3:0] rda_addr,
	output logic      [5:0] rda_ff,
	input  wire logic [3:0] rdb_addr,
	output logic      [5:0] rdb_ff
);
	logic [5:0] mem_ff [16];
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end
	always_ff @(posedge clock) begin
		if (rda_en) begin
			rda_ff <= mem_ff[rda_addr];
		end
		rdb_ff <= mem_ff[rdb_addr];
	end
endmodule

/* File: apm_top.sv */
// Attribute controller: register port, dot/attribute mapping, palette, panning, output
`timescale 1ns/1ps
`include "apm_defs.svh"
module apm_top import apm_pkg::*; (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [1:0]  io_sel,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata_ff,
	input  wire logic        key_unlocked,
	input  wire logic [7:0]  timer_status,
	input  wire logic        pix_valid,
	output logic             pix_ready,
	input  wire logic        pix_border,
	input  wire logic        pix_linear,
	input  wire logic        pix_blink_phase,
	input  wire logic        pix_underline_row,
	input  wire logic [3:0]  pix_box_width,
	input  wire logic [3:0]  pix_dot,
	input  wire logic [7:0]  pix_code,
	input  wire logic [7:0]  pix_glyph,
	input  wire logic [7:0]  pix_plane3,
	input  wire logic [7:0]  pix_attr,
	output logic      [15:0] pixel_output_bus_ff,
	output logic             out_valid_ff,
	input  wire logic        out_ready,
	output logic      [2:0]  font_select_ff,
	output logic             font_override_ff
);
	localparam int FW = 44;
	apm_port_e  port_ff;
	logic       pal_src_ff;
	logic [4:0] index_ff;
	logic [7:0] mode_ff, border_ff, plane_ff, shift_ff, hicolor_ff, outcfg_ff, redef_ff;
	logic       data_wr, status_rd, pal_wr;
	logic [5:0] pal_a, pal_b;
	logic [FW-1:0] f_data;
	logic       f_valid, f_pop, advance;
	logic       f_border, f_linear, f_phase, f_uline;
	logic [3:0] f_width, f_dot;
	logic [7:0] f_code, f_glyph, f_p3, f_attr;
	logic       dot_on;
	logic [3:0] nxt_idx;
	logic       nxt_direct;
	apm_color_t nxt_dcol;
	logic [2:0] nxt_font;
	logic       a_valid_ff, a_border_ff, a_direct_ff;
	logic [3:0] a_idx_ff;
	apm_color_t a_dcol_ff, b_col;
	apm_color_t hist_ff [`APM_PAN_TAPS];
	logic [`APM_PAN_TAPS-1:0] hv_ff;
	logic [3:0] tap;
	logic       half_ff;
	logic [7:0] low_ff;

	function automatic logic [3:0] pan_shift(input logic [3:0] pan, input logic [3:0] w);
		logic [3:0] s;
		s = 4'h0;
		unique case (w)
			// Wrapping, or clamping at nine for other widths, keeps the tap inside the ten-pixel history for any panning value
			4'h6: s = 4'((5'(pan) + 5'h04) % 5'h06);
			4'h7: s = 4'((5'(pan) + 5'h06) % 5'h07);
			4'h9: s = (pan < 4'h8) ? pan + 4'h1 : 4'h0;
			default: s = (pan > 4'h9) ? 4'h9 : pan;
		endcase
		return s;
	endfunction

	function automatic logic ninth_dot(input logic [7:0] glyph, input logic [7:0] p3, input logic [7:0] code,
		input logic [3:0] dot, input logic [3:0] w, input logic lg);
		logic r;
		r = 1'b0;
		if (dot < 4'h8) begin
			r = glyph[3'(4'h7 - dot)];
		end else if (w == 4'h9) begin
			if (lg) begin
				r = (code >= `APM_LG_LO && code <= `APM_LG_HI) ? glyph[0] : 1'b0;
			end else begin
				r = p3[7];
			end
		end else begin
			r = p3[3'(4'hf - dot)];
		end
		return r;
	endfunction

	assign data_wr   = io_wr && io_sel == APM_SEL_ATTR && port_ff == APM_PORT_DATA;
	assign status_rd = io_rd && io_sel == APM_SEL_STATUS;
	// Palette writes are dropped while protected, so a stray write cannot spoil live video
	assign pal_wr    = data_wr && !index_ff[4] && !outcfg_ff[`APM_CFG_DPROT] && !redef_ff[`APM_REDEF_BIT];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			port_ff <= APM_PORT_INDEX;
		end else if (status_rd) begin
			port_ff <= APM_PORT_INDEX;
		end else if (io_wr && io_sel == APM_SEL_ATTR) begin
			port_ff <= (port_ff == APM_PORT_INDEX) ? APM_PORT_DATA : APM_PORT_INDEX;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			index_ff   <= '0;
			pal_src_ff <= 1'b0;
		end else if (io_wr && io_sel == APM_SEL_ATTR && port_ff == APM_PORT_INDEX && !status_rd) begin
			index_ff   <= io_wdata[4:0];
			pal_src_ff <= io_wdata[5];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mode_ff    <= `APM_REG_RESET;
			border_ff  <= `APM_REG_RESET;
			plane_ff   <= `APM_REG_RESET;
			shift_ff   <= `APM_REG_RESET;
			hicolor_ff <= `APM_REG_RESET;
			outcfg_ff  <= `APM_REG_RESET;
			redef_ff   <= `APM_REG_RESET;
		end else if (data_wr) begin
			unique case (index_ff)
				`APM_IDX_MODE:    mode_ff <= io_wdata & `APM_MASK_MODE;
				`APM_IDX_BORDER: begin
					border_ff[7:4] <= io_wdata[7:4];
					if (!outcfg_ff[`APM_CFG_BPROT]) begin
						border_ff[3:0] <= io_wdata[3:0];
					end
				end
				`APM_IDX_PLANE:   plane_ff <= io_wdata & `APM_MASK_PLANE;
				`APM_IDX_SHIFT:   shift_ff <= io_wdata & `APM_MASK_SHIFT;
				`APM_IDX_HICOLOR: hicolor_ff <= io_wdata & `APM_MASK_HICOLOR;
				`APM_IDX_OUTCFG: begin
					if (key_unlocked) begin
						outcfg_ff <= io_wdata & `APM_MASK_OUTCFG;
					end
				end
				`APM_IDX_REDEF: begin
					if (key_unlocked) begin
						redef_ff <= io_wdata & `APM_MASK_REDEF;
					end
				end
				default: ;
			endcase
		end
	end

	// Status pair follows the last colour sent, a cheap loopback for display tests
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			io_rdata_ff <= 8'h00;
		end else if (io_rd) begin
			unique case (io_sel)
				APM_SEL_ATTR:   io_rdata_ff <= {2'b00, pal_src_ff, index_ff};
				APM_SEL_STATUS: begin
					io_rdata_ff <= timer_status;
					unique case (plane_ff[5:4])
						2'b00: io_rdata_ff[5:4] <= {low_ff[2], low_ff[0]};
						2'b01: io_rdata_ff[5:4] <= {low_ff[5], low_ff[4]};
						2'b10: io_rdata_ff[5:4] <= {low_ff[3], low_ff[1]};
						2'b11: io_rdata_ff[5:4] <= {low_ff[7], low_ff[6]};
					endcase
				end
				default: begin
					unique case (index_ff)
						`APM_IDX_MODE:    io_rdata_ff <= mode_ff;
						`APM_IDX_BORDER:  io_rdata_ff <= border_ff;
						`APM_IDX_PLANE:   io_rdata_ff <= plane_ff;
						`APM_IDX_SHIFT:   io_rdata_ff <= shift_ff;
						`APM_IDX_HICOLOR: io_rdata_ff <= hicolor_ff;
						`APM_IDX_OUTCFG:  io_rdata_ff <= outcfg_ff;
						`APM_IDX_REDEF:   io_rdata_ff <= redef_ff;
						default:          io_rdata_ff <= index_ff[4] ? 8'h00 : {2'b00, pal_b};
					endcase
				end
			endcase
		end
	end

	apm_fifo #(.WIDTH(FW), .DEPTH(`APM_FIFO_DEPTH)) u_fifo (
		.clock     (clock),
		.resetn    (resetn),
		.in_valid  (pix_valid),
		.in_ready  (pix_ready),
		.in_data   ({pix_border, pix_linear, pix_blink_phase, pix_underline_row, pix_box_width, pix_dot,
		              pix_code, pix_glyph, pix_plane3, pix_attr}),
		.out_valid (f_valid),
		.out_ready (advance),
		.out_data  (f_data)
	);

	// Downstream stall reaches the FIFO, which then fills and drops pix_ready
	assign advance = !out_valid_ff || out_ready;
	assign f_pop   = f_valid && advance;
	assign {f_border, f_linear, f_phase, f_uline, f_width, f_dot, f_code, f_glyph, f_p3, f_attr} = f_data;
	assign dot_on  = ninth_dot(f_glyph, f_p3, f_code, f_dot, f_width, mode_ff[`APM_MODE_LGFX]);

	always_comb begin
		logic [2:0] rgb;
		logic       lit;
		rgb        = 3'h0;
		lit        = 1'b0;
		nxt_idx    = 4'h0;
		nxt_direct = 1'b0;
		nxt_dcol   = 8'h00;
		nxt_font   = 3'h0;
		if (f_linear) begin
			nxt_direct = 1'b1;
			nxt_dcol   = f_attr;
		end else if (mode_ff[`APM_MODE_GFX]) begin
			nxt_idx = f_attr[3:0] & plane_ff[3:0];
			if (mode_ff[`APM_MODE_BLINK] && nxt_idx[3]) begin
				nxt_idx[3] = !f_phase;
			end
		end else if (redef_ff[`APM_REDEF_BIT]) begin
			nxt_direct = 1'b1;
			if (mode_ff[`APM_MODE_MONO]) begin
				nxt_font = f_attr[2:0];
				lit = !f_attr[5] && ((dot_on || (f_uline && f_attr[4])) ^ f_attr[7]) && !(f_attr[3] && f_phase);
				nxt_dcol = lit ? (f_attr[6] ? `APM_HALF_LEVEL : `APM_FULL_LEVEL) : 8'h00;
			end else begin
				nxt_font = {1'b0, f_attr[1:0]};
				rgb      = dot_on ? f_attr[4:2] : f_attr[7:5];
				nxt_dcol = {1'b0, rgb, 1'b0, rgb};
			end
		end else if (mode_ff[`APM_MODE_MONO]) begin
			nxt_idx = dot_on ? {f_attr[3], 3'h7} : 4'h0;
			if (f_attr[6:0] == 7'h70) begin
				nxt_idx = dot_on ? 4'h0 : 4'h7;
			end
		end else begin
			nxt_idx = dot_on ? f_attr[3:0] : f_attr[7:4];
			if (mode_ff[`APM_MODE_BLINK]) begin
				nxt_idx = dot_on ? f_attr[3:0] : {1'b0, f_attr[6:4]};
				nxt_idx[3] = nxt_idx[3] ^ (f_attr[7] && f_phase);
			end
		end
	end

	apm_palette_mem u_pal (
		.clock    (clock),
		.wr_en    (pal_wr),
		.wr_addr  (index_ff[3:0]),
		.wr_data  (io_wdata[5:0]),
		.rda_en   (advance),
		.rda_addr (nxt_idx),
		.rda_ff   (pal_a),
		.rdb_addr (index_ff[3:0]),
		.rdb_ff   (pal_b)
	);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			a_valid_ff       <= 1'b0;
			a_border_ff      <= 1'b0;
			a_direct_ff      <= 1'b0;
			a_idx_ff         <= 4'h0;
			a_dcol_ff        <= 8'h00;
			font_select_ff   <= 3'h0;
			font_override_ff <= 1'b0;
		end else if (advance) begin
			a_valid_ff  <= f_pop;
			a_border_ff <= f_border || !pal_src_ff;
			a_direct_ff <= nxt_direct;
			a_idx_ff    <= nxt_idx;
			a_dcol_ff   <= nxt_dcol;
			if (f_pop) begin
				font_select_ff   <= nxt_font;
				font_override_ff <= redef_ff[`APM_REDEF_BIT] && !f_linear && !mode_ff[`APM_MODE_GFX];
			end
		end
	end

	always_comb begin
		if (a_border_ff) begin
			b_col = border_ff;
		end else if (a_direct_ff) begin
			b_col = a_dcol_ff;
		end else if (outcfg_ff[`APM_CFG_BYPASS]) begin
			b_col = {4'h0, a_idx_ff};
		end else begin
			b_col = {hicolor_ff[3:2], mode_ff[`APM_MODE_SECSEL] ? hicolor_ff[1:0] : pal_a[5:4], pal_a[3:0]};
		end
	end

	// Panning costs up to ten pixels of latency; the tap picks a later pixel to shift left
	genvar g;
	generate
		for (g = 0; g < `APM_PAN_TAPS; g++) begin : g_pan
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					hist_ff[g] <= 8'h00;
					hv_ff[g]   <= 1'b0;
				end else if (advance) begin
					hist_ff[g] <= (g == 0) ? b_col : hist_ff[(g == 0) ? 0 : g-1];
					hv_ff[g]   <= (g == 0) ? a_valid_ff : hv_ff[(g == 0) ? 0 : g-1];
				end
			end
		end
	endgenerate
	assign tap = 4'h9 - pan_shift(shift_ff[3:0], f_width);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pixel_output_bus_ff <= 16'h0000;
			out_valid_ff        <= 1'b0;
			half_ff             <= 1'b0;
			low_ff              <= 8'h00;
		end else if (advance) begin
			out_valid_ff <= 1'b0;
			if (hv_ff[tap]) begin
				low_ff <= hist_ff[tap];
				if (outcfg_ff[5:4] == `APM_WIDE_CODE) begin
					half_ff <= !half_ff;
					if (half_ff) begin
						pixel_output_bus_ff <= {hist_ff[tap], low_ff};
						out_valid_ff        <= 1'b1;
					end
				end else begin
					half_ff             <= 1'b0;
					pixel_output_bus_ff <= {8'h00, hist_ff[tap]};
					out_valid_ff        <= 1'b1;
				end
			end
		end
	end

	port_toggle_a: assert property (@(posedge clock) disable iff (!resetn)
		(io_wr && io_sel == APM_SEL_ATTR && !status_rd) |=> port_ff != $past(port_ff))
		else $error("index/data state did not flip on write");
	status_index_a: assert property (@(posedge clock) disable iff (!resetn)
		status_rd |=> port_ff == APM_PORT_INDEX)
		else $error("status read did not return to index state");
	key_lock_a: assert property (@(posedge clock) disable iff (!resetn)
		(data_wr && !key_unlocked && index_ff == `APM_IDX_OUTCFG) |=> $stable(outcfg_ff))
		else $error("locked register changed");
	border_guard_a: assert property (@(posedge clock) disable iff (!resetn)
		outcfg_ff[`APM_CFG_BPROT] |=> border_ff[3:0] == $past(border_ff[3:0]))
		else $error("protected border bits changed");
	palette_guard_a: assert property (@(posedge clock) disable iff (!resetn)
		(data_wr && !index_ff[4] && $stable(index_ff) && (outcfg_ff[`APM_CFG_DPROT] || redef_ff[`APM_REDEF_BIT]))
		|=> ##1 pal_b == $past(pal_b, 2))
		else $error("palette written while protected");
	narrow_out_a: assert property (@(posedge clock) disable iff (!resetn)
		(outcfg_ff[5:4] == 2'b00 && advance && hv_ff[tap]) |=> out_valid_ff && pixel_output_bus_ff[15:8] == 8'h00)
		else $error("eight-bit output malformed");
	nine_pan_a: assert property (@(posedge clock) disable iff (!resetn)
		(f_width == 4'h9 && shift_ff[3:0] == 4'h8) |-> tap == 4'h9)
		else $error("pan 8 in nine-dot mode shifted");
	lg_zero_a: assert property (@(posedge clock) disable iff (!resetn)
		(mode_ff[`APM_MODE_LGFX] && f_width == 4'h9 && f_dot == 4'h8 && f_code < `APM_LG_LO) |-> !dot_on)
		else $error("ninth dot not zero outside line-graphics range");
	border_out_a: assert property (@(posedge clock) disable iff (!resetn)
		(advance && a_border_ff) |=> hist_ff[0] == $past(border_ff))
		else $error("border colour not shown");
endmodule

/* File: apm_dac_model.sv */
// Colour DAC stand-in that takes output words, with stall and slow modes
`timescale 1ns/1ps
module apm_dac_model (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        valid,
	input  wire logic [15:0] data,
	input  wire logic        stall,
	input  wire logic        slow,
	output logic             ready,
	output logic      [15:0] last_ff,
	output logic      [15:0] count_ff
);
	logic ph_ff;
	// Slow mode drops ready every other cycle so the output hold is exercised
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			ph_ff <= 1'b0;
		else
			ph_ff <= ~ph_ff;
	end
	assign ready = !stall && !(slow && ph_ff);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			last_ff  <= 16'h0000;
			count_ff <= 16'h0000;
		end else if (valid && ready) begin
			last_ff  <= data;
			count_ff <= count_ff + 16'h0001;
		end
	end
endmodule

/* File: tb_apm_top.sv */
// Self-checking bench for the attribute pixel mapper
`timescale 1ns/1ps
`include "apm_defs.svh"
module tb_apm_top;
	logic        clock, resetn = 0, io_wr = 0, io_rd = 0, key_unlocked = 0, pix_valid = 0;
	logic        pix_border = 0, pix_linear = 0, stall = 0, slow = 0, pix_ready, out_valid_ff, out_ready;
	logic        phase = 0, uline = 0, font_ovr;
	logic [2:0]  font_sel;
	logic [1:0]  io_sel = 0;
	logic [3:0]  pix_box_width = 4'h9, pix_dot = 0;
	logic [7:0]  io_wdata = 0, timer_status = 8'hcf, pix_code = 0, pix_glyph = 0, pix_plane3 = 0, pix_attr = 0;
	logic [7:0]  io_rdata_ff, v;
	logic [15:0] pixel_output_bus_ff, last_w, cnt_w;
	logic [4:0]  ix [7] = '{`APM_IDX_MODE, `APM_IDX_BORDER, `APM_IDX_PLANE, `APM_IDX_SHIFT,
		`APM_IDX_HICOLOR, `APM_IDX_OUTCFG, `APM_IDX_REDEF};
	logic [7:0]  mk [7] = '{`APM_MASK_MODE, 8'hff, `APM_MASK_PLANE, `APM_MASK_SHIFT,
		`APM_MASK_HICOLOR, `APM_MASK_OUTCFG, `APM_MASK_REDEF};
	logic [1:0]  sp [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
	int          err_count = 0, n_tests = 0, cyc = 0, k;
	apm_top i_apm_top (.clock(clock), .resetn(resetn), .io_wr(io_wr), .io_rd(io_rd), .io_sel(io_sel),
		.io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .key_unlocked(key_unlocked),
		.timer_status(timer_status), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_border(pix_border),
		.pix_linear(pix_linear), .pix_blink_phase(phase), .pix_underline_row(uline),
		.pix_box_width(pix_box_width), .pix_dot(pix_dot), .pix_code(pix_code), .pix_glyph(pix_glyph),
		.pix_plane3(pix_plane3), .pix_attr(pix_attr), .pixel_output_bus_ff(pixel_output_bus_ff),
		.out_valid_ff(out_valid_ff), .out_ready(out_ready), .font_select_ff(font_sel), .font_override_ff(font_ovr));
	apm_dac_model i_apm_dac_model (.clock(clock), .resetn(resetn), .valid(out_valid_ff),
		.data(pixel_output_bus_ff), .stall(stall), .slow(slow), .ready(out_ready), .last_ff(last_w),
		.count_ff(cnt_w));
	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	// Sized well above the whole run so a stuck handshake cannot hang it
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish;
		end
	end
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] ib(input int i);
		return {3'b001, ix[i]};
	endfunction
	task automatic do_reset;
		@(negedge clock);
		resetn = 1'b0;
		repeat (5) @(negedge clock);
		resetn = 1'b1;
	endtask
	task automatic wr(input logic [7:0] b);
		@(negedge clock);
		io_wr = 1'b1;
		io_sel = 2'b00;
		io_wdata = b;
		@(negedge clock);
		io_wr = 1'b0;
	endtask
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		@(negedge clock);
		io_rd = 1'b1;
		io_sel = s;
		@(negedge clock);
		io_rd = 1'b0;
		repeat (2) @(negedge clock);
		d = io_rdata_ff;
	endtask
	// A status read first puts the port back in index state
	task automatic wreg(input logic [7:0] b, input logic [7:0] d);
		rd(2'b10, v);
		wr(b);
		wr(d);
	endtask
	task automatic rreg(input logic [7:0] b, input logic [7:0] e);
		rd(2'b10, v);
		wr(b);
		repeat (2) @(negedge clock);
		rd(2'b01, v);
		chk({8'h00, v}, {8'h00, e});
	endtask
	task automatic push(input logic [7:0] a, cd, g, p3, input logic [3:0] bw, dt, input logic b, ln);
		@(negedge clock);
		pix_valid = 1'b1;
		pix_attr = a;
		pix_code = cd;
		pix_glyph = g;
		pix_plane3 = p3;
		pix_box_width = bw;
		pix_dot = dt;
		pix_border = b;
		pix_linear = ln;
		k = 0;
		while (pix_ready !== 1'b1 && k < 300) begin
			@(negedge clock);
			k++;
		end
		@(posedge clock);
	endtask
	task automatic burst(input int n, input logic [7:0] a, st, cd, g, p3, input logic [3:0] bw, dt,
		input logic b, ln);
		for (int i = 0; i < n; i++)
			push(a + st * 8'(i), cd, g, p3, bw, dt, b, ln);
		@(negedge clock);
		pix_valid = 1'b0;
		repeat (40) @(negedge clock);
	endtask
	// Twelve equal pixels flush the ten-deep history before the last word is judged
	task automatic cs(input logic [7:0] m, pl, a, cd, g, p3, input logic [3:0] bw, dt, input logic b,
		input logic [7:0] e);
		wreg(ib(0), m);
		wreg(ib(2), pl);
		burst(12, a, 8'h00, cd, g, p3, bw, dt, b, 1'b0);
		chk(last_w, {8'h00, e});
	endtask
	task automatic pan(input logic [3:0] bw, input logic [7:0] pv, input int s);
		do_reset;
		wreg(ib(3), pv);
		for (int i = 0; i < 20; i++)
			push(8'h40 + 8'(i), 8'h00, 8'h00, 8'h00, bw, 4'h0, 1'b0, 1'b1);
		// Every pixel still leaves; a shift only shortens latency, so look mid-stream
		@(negedge clock);
		chk(last_w, {8'h00, 8'h46 + 8'(s)});
		pix_valid = 1'b0;
		repeat (40) @(negedge clock);
		chk(cnt_w, 16'h0014);
	endtask
	initial begin
		do_reset;
		for (int i = 0; i < 7; i++) rreg(ib(i), 8'h00);
		for (int i = 0; i < 7; i++) wreg(ib(i), 8'hff);
		for (int i = 0; i < 7; i++) rreg(ib(i), (i >= 5) ? 8'h00 : mk[i]);
		key_unlocked = 1'b1;
		wreg(ib(5), 8'hff);
		wreg(ib(6), 8'hff);
		rreg(ib(5), `APM_MASK_OUTCFG);
		rreg(ib(6), `APM_MASK_REDEF);
		wreg(ib(1), 8'h00);
		rreg(ib(1), 8'h0f);
		wreg(ib(5), 8'h00);
		wreg(ib(6), 8'h00);
		wreg(8'h03, 8'h2a);
		rreg(8'h03, 8'h2a);
		wreg(ib(5), 8'h02);
		wreg(8'h03, 8'h15);
		rreg(8'h03, 8'h2a);
		wreg(ib(5), 8'h00);
		wreg(ib(6), 8'h80);
		wreg(8'h03, 8'h15);
		rreg(8'h03, 8'h2a);
		wr(8'h33);
		rd(2'b10, v);
		wr(8'h34);
		wr(8'h05);
		rreg(8'h34, 8'h05);
		rreg(8'h33, 8'h0f);
		// Bypass exposes the palette index directly, so no palette contents are needed
		do_reset;
		wreg(ib(5), 8'h80);
		wreg(ib(1), 8'ha5);
		cs(8'h04, 8'h0f, 8'h1e, 8'hc0, 8'h01, 8'h00, 4'h9, 4'h8, 1'b0, 8'h0e);
		cs(8'h04, 8'h0f, 8'h1e, 8'hdf, 8'h01, 8'h00, 4'h9, 4'h8, 1'b0, 8'h0e);
		cs(8'h04, 8'h0f, 8'h1e, 8'hbf, 8'h01, 8'h00, 4'h9, 4'h8, 1'b0, 8'h01);
		cs(8'h04, 8'h0f, 8'h1e, 8'he0, 8'h01, 8'h00, 4'h9, 4'h8, 1'b0, 8'h01);
		cs(8'h00, 8'h0f, 8'h1e, 8'hc0, 8'h01, 8'h80, 4'h9, 4'h8, 1'b0, 8'h0e);
		cs(8'h00, 8'h0f, 8'h1e, 8'hc0, 8'h01, 8'h00, 4'h9, 4'h8, 1'b0, 8'h01);
		cs(8'h00, 8'h0f, 8'h1e, 8'h00, 8'h00, 8'h40, 4'ha, 4'h9, 1'b0, 8'h0e);
		cs(8'h02, 8'h0f, 8'h01, 8'h00, 8'h80, 8'h00, 4'h8, 4'h0, 1'b0, 8'h07);
		cs(8'h00, 8'h0f, 8'h01, 8'h00, 8'h80, 8'h00, 4'h8, 4'h0, 1'b0, 8'h01);
		cs(8'h01, 8'h05, 8'h0f, 8'h00, 8'h00, 8'h00, 4'h8, 4'h0, 1'b0, 8'h05);
		cs(8'h01, 8'h0a, 8'h0f, 8'h00, 8'h00, 8'h00, 4'h8, 4'h0, 1'b0, 8'h0a);
		cs(8'h00, 8'h0f, 8'h1e, 8'h00, 8'h00, 8'h00, 4'h9, 4'h0, 1'b1, 8'ha5);
		phase = 1'b1;
		cs(8'h08, 8'h0f, 8'h81, 8'h00, 8'h00, 8'h00, 4'h8, 4'h0, 1'b0, 8'h08);
		phase = 1'b0;
		wreg(ib(6), 8'h80);
		cs(8'h00, 8'h0f, 8'hb2, 8'h00, 8'h80, 8'h00, 4'h8, 4'h0, 1'b0, 8'h44);
		chk({13'h0000, font_sel}, 16'h0002);
		cs(8'h02, 8'h0f, 8'hc5, 8'h00, 8'h00, 8'h00, 4'h8, 4'h0, 1'b0, 8'h08);
		chk({13'h0000, font_sel}, 16'h0005);
		chk({15'h0000, font_ovr}, 16'h0001);
		uline = 1'b1;
		cs(8'h02, 8'h0f, 8'h10, 8'h00, 8'h00, 8'h00, 4'h8, 4'h0, 1'b0, 8'h18);
		uline = 1'b0;
		wreg(ib(6), 8'h00);
		wreg(ib(5), 8'h00);
		wreg(8'h01, 8'h3a);
		wreg(ib(4), 8'h0d);
		cs(8'h80, 8'h0f, 8'h01, 8'h00, 8'h80, 8'h00, 4'h8, 4'h0, 1'b0, 8'hda);
		chk({15'h0000, font_ovr}, 16'h0000);
		cs(8'h00, 8'h0f, 8'h01, 8'h00, 8'h80, 8'h00, 4'h8, 4'h0, 1'b0, 8'hfa);
		pan(4'h9, 8'h08, 0);
		pan(4'h9, 8'h00, 1);
		pan(4'h9, 8'h07, 8);
		pan(4'h6, 8'h02, 0);
		pan(4'h7, 8'h01, 0);
		pan(4'h8, 8'h03, 3);
		// This byte gives each status pair a different two-bit value
		burst(1, 8'hd8, 8'h00, 8'h00, 8'h00, 8'h00, 4'h8, 4'h0, 1'b0, 1'b1);
		chk(last_w, {8'h00, 8'hd8});
		for (int s = 0; s < 4; s++) begin
			wreg(ib(2), {2'b00, 2'(s), 4'h0});
			rd(2'b10, v);
			chk({8'h00, v}, {8'h00, 8'hcf | {2'b00, sp[s], 4'h0}});
		end
		do_reset;
		slow = 1'b1;
		wreg(ib(5), 8'h20);
		burst(21, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 4'h8, 4'h0, 1'b0, 1'b1);
		chk({8'h00, last_w[15:8] - last_w[7:0]}, 16'h0001);
		chk(cnt_w, 16'h000a);
		slow = 1'b0;
		// Stalled DAC: the buffer must fill and refuse, then drain once released
		do_reset;
		stall = 1'b1;
		@(negedge clock);
		pix_valid = 1'b1;
		k = 0;
		while (pix_ready === 1'b1 && k < 40) begin
			@(negedge clock);
			k++;
		end
		chk({15'h0000, k >= `APM_FIFO_DEPTH}, 16'h0001);
		chk({15'h0000, pix_ready}, 16'h0000);
		pix_valid = 1'b0;
		stall = 1'b0;
		repeat (40) @(negedge clock);
		chk({15'h0000, pix_ready}, 16'h0001);
		tally_and_finish;
	end
endmodule
